// *** sbsc_assertions.sv ***
// Port checker for the burst SRAM control block.
// Assumes pins sit idle during reset; pins act three samples later.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"
module sbsc_assertions (
  input wire logic clk, srst,                         // Clock, reset
  input wire logic chipSelFirstN, depthSelHigh,       // Selects
  input wire logic depthSelLowN, burstStepN,          // Select, advance
  input wire logic procAddrStrobeN, ctrlAddrStrobeN,  // Strobes
  input wire logic globalWriteN, byteQualifiedWriteN, // Writes
  input wire logic outEnN,                            // Output enable
  input wire logic [`SBSC_DATA_W-1:0] dataIoOut,      // Read data
  input wire logic dataIoOe                           // Data drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire sel = !chipSelFirstN && depthSelHigh && !depthSelLowN;
  wire idl = procAddrStrobeN && ctrlAddrStrobeN;
  wire rdo = globalWriteN && byteQualifiedWriteN;
  property p_oe; outEnN |-> !dataIoOe; endproperty
  a_oe: assert property (p_oe) else $error("drive while disabled");
  property p_dsC; $past(!ctrlAddrStrobeN && !sel &&
    (chipSelFirstN || procAddrStrobeN), 3) |-> !dataIoOe; endproperty
  a_dsC: assert property (p_dsC) else $error("no deselect");
  property p_dsP; $past(!procAddrStrobeN && !chipSelFirstN && !sel, 3)
    |-> !dataIoOe; endproperty
  a_dsP: assert property (p_dsP) else $error("no deselect");
  property p_bRd; $past(sel && (!procAddrStrobeN || !ctrlAddrStrobeN &&
    rdo), 3) && !outEnN |-> dataIoOe; endproperty
  a_bRd: assert property (p_bRd) else $error("read not begun");
  property p_bWr; $past(sel && procAddrStrobeN && !ctrlAddrStrobeN &&
    !globalWriteN, 3) |-> !dataIoOe; endproperty
  a_bWr: assert property (p_bWr) else $error("write drove");
  property p_cRd; $past(idl && !burstStepN && rdo, 3) && $past(dataIoOe)
    && !outEnN |-> dataIoOe; endproperty
  a_cRd: assert property (p_cRd) else $error("read dropped");
  property p_sRd; $past(idl && burstStepN && rdo, 3) && $past(dataIoOe)
    && !outEnN |-> dataIoOe && $stable(dataIoOut); endproperty
  a_sRd: assert property (p_sRd) else $error("suspend moved");
  property p_cWr; $past(idl && !globalWriteN, 3) |-> !dataIoOe;
  endproperty
  a_cWr: assert property (p_cWr) else $error("write drove");
endmodule : sbsc_assertions
bind sbsc_sync_burst_sram_control sbsc_assertions chk (.*);
`default_nettype wire

// *** sbsc_cache_ctl.sv ***
// Cache controller side: output enable handling around writes.
// Assumes write pins come from the bench on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sbsc_cache_ctl (
  input  wire logic clk,    // Clock
  input  wire logic srst,   // Sync reset
  input  wire logic wrInd,  // Write shown on pins
  input  wire logic oeWant, // Bench wants read data
  output logic      outEnN  // Output enable to device
);
  logic [1:0] holdReg, holdNext;
  // Device decodes pins late, so stay off until the write has landed
  always_comb
    holdNext = wrInd ? 2'h3
             : (holdReg == 2'h0 ? 2'h0 : holdReg - 2'h1);
  always_ff @(posedge clk) holdReg <= srst ? 2'h0 : holdNext;
  assign outEnN = !oeWant || wrInd || (holdReg != 2'h0);
endmodule : sbsc_cache_ctl
`default_nettype wire

// *** sbsc_map.svh ***
// Constants of the synchronous burst SRAM control block.
// Assumes inclusion by bare name from the package and the design.
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH

`define SBSC_ADDR_W    16
`define SBSC_DATA_W    18
`define SBSC_BYTE_W    9
`define SBSC_BYTES     2
`define SBSC_DEPTH     65536
`define SBSC_BURST_W   2
`define SBSC_CTRL_W    10
`define SBSC_SYNC_W    44
`define SBSC_ADDR_LSB  18
`define SBSC_CTRL_LSB  34
`define SBSC_ADDR_RST  16'h0000
`define SBSC_CNT_RST   2'h0
`define SBSC_CNT_STEP  2'h1
`define SBSC_SYNC_RST  44'hFFF_FFFF_FFFF

`endif

// *** sbsc_pkg.sv ***
// Types shared by the synchronous burst SRAM control block.
// Assumes sbsc_map.svh is on the include path.
`include "sbsc_map.svh"

package sbsc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } sbsc_state_e;

endpackage : sbsc_pkg

// *** sbsc_sync_burst_sram_control.sv ***
// Flow-through burst SRAM core: 64K x 18, two 9-bit bytes, burst counter.
// Assumes one clock; every pin except reset, clock enable, output enable and burst order is
// asynchronous to clk and is brought in through two flip-flops.
// Operation
// - Third select is active-low depth enable, sampled.
// - Global write writes both bytes, overriding others.
// - Qualified write writes only bytes enabled low.
// - Write when global, or qualified plus byte.
// - Output enable unregistered, drives data combinationally.
// - Controller strobe deselects when any select off.
// - Processor strobe deselects when depth selects off.
// - Selected strobe starts read at external address.
// - Idle strobes, step low: read next address.
// - Idle strobes, step high: hold address, re-present.
// - Write begins external or at current address.
// - Idle strobes, step low, write: next address.
// - Idle strobes, step high, write: repeat current.
// - Qualified write picks each byte by its input.
// - Global write low writes all bytes.
// - Burst order pin static: low linear, high interleaved.
// - First select high ignores processor strobe.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module sbsc_sync_burst_sram_control (
  input  wire logic                      clk,                // 100 MHz clock
  input  wire logic                      srst,               // Sync reset
  input  wire logic                      ce,                 // Clock enable
  input  wire logic                      chipSelFirstN,      // First select
  input  wire logic                      depthSelHigh,       // Depth select
  input  wire logic                      depthSelLowN,       // Depth select
  input  wire logic                      procAddrStrobeN,    // Proc strobe
  input  wire logic                      ctrlAddrStrobeN,    // Ctrl strobe
  input  wire logic                      burstStepN,         // Burst advance
  input  wire logic                      globalWriteN,       // Global write
  input  wire logic                      byteQualifiedWriteN,// Qualified wr
  input  wire logic                      byteLowWriteN,      // Byte a write
  input  wire logic                      byteHighWriteN,     // Byte b write
  input  wire logic                      outEnN,             // Async out en
  input  wire logic                      burstOrderSel,      // 1=interleave
  input  wire logic [`SBSC_ADDR_W-1:0]   addressIn,          // Word address
  input  wire logic [`SBSC_DATA_W-1:0]   dataIoIn,           // Data pin in
  output logic      [`SBSC_DATA_W-1:0]   dataIoOut,          // Data pin out
  output logic                           dataIoOe            // Data drive
);

  // Two-stage input synchroniser; stage one feeds only stage two
  logic [`SBSC_SYNC_W-1:0] syncA_reg;
  logic [`SBSC_SYNC_W-1:0] syncA_next;
  logic [`SBSC_SYNC_W-1:0] syncB_reg;
  logic [`SBSC_SYNC_W-1:0] syncB_next;
  logic [`SBSC_SYNC_W-1:0] pinsRaw;

  assign pinsRaw = {chipSelFirstN, depthSelHigh, depthSelLowN,
                    procAddrStrobeN, ctrlAddrStrobeN, burstStepN,
                    globalWriteN, byteQualifiedWriteN,
                    byteHighWriteN, byteLowWriteN, addressIn, dataIoIn};

  always_comb begin
    syncA_next = syncA_reg;
    syncB_next = syncB_reg;
    if (srst) begin
      syncA_next = `SBSC_SYNC_RST;
      syncB_next = `SBSC_SYNC_RST;
    end else if (ce) begin
      syncA_next = pinsRaw;
      syncB_next = syncA_reg;
    end
  end

  always_ff @(posedge clk) begin
    syncA_reg <= syncA_next;
    syncB_reg <= syncB_next;
  end

  // Sampled controls, as seen at the decoding edge
  logic                      sCs1N;
  logic                      sCs2;
  logic                      sCs3N;
  logic                      sAdspN;
  logic                      sAdscN;
  logic                      sStepN;
  logic                      sGwN;
  logic                      sBqN;
  logic [`SBSC_BYTES-1:0]    sBwN;
  logic [`SBSC_ADDR_W-1:0]   sAddr;
  logic [`SBSC_DATA_W-1:0]   sData;

  assign {sCs1N, sCs2, sCs3N, sAdspN, sAdscN, sStepN, sGwN, sBqN, sBwN} =
    syncB_reg[`SBSC_SYNC_W-1:`SBSC_CTRL_LSB];
  assign sAddr = syncB_reg[`SBSC_CTRL_LSB-1:`SBSC_ADDR_LSB];
  assign sData = syncB_reg[`SBSC_ADDR_LSB-1:0];

  // Write qualification
  logic                   globalWr;
  logic [`SBSC_BYTES-1:0] byteMask;
  logic                   isWrite;

  assign globalWr = ~sGwN;
  assign byteMask = {`SBSC_BYTES{globalWr}}
                  | ({`SBSC_BYTES{~sBqN}} & ~sBwN);
  assign isWrite  = |byteMask;

  // Burst address ordering on the two low bits
  function automatic logic [`SBSC_BURST_W-1:0] burstLow(
    input logic [`SBSC_BURST_W-1:0] start,
    input logic [`SBSC_BURST_W-1:0] cnt,
    input logic                     interleave
  );
    burstLow = interleave ? (start ^ cnt)
                          : (start + cnt);
  endfunction : burstLow

  // Cycle state, address and burst counter
  sbsc_pkg::sbsc_state_e     state_reg;
  sbsc_pkg::sbsc_state_e     state_next;
  logic [`SBSC_ADDR_W-1:0]   addr_reg;
  logic [`SBSC_ADDR_W-1:0]   addr_next;
  logic [`SBSC_BURST_W-1:0]  cnt_reg;
  logic [`SBSC_BURST_W-1:0]  cnt_next;
  logic                      selected;
  logic                      procStart;
  logic [`SBSC_BYTES-1:0]    memWe;
  logic [`SBSC_ADDR_W-1:0]   wordAddrNext;
  logic [`SBSC_ADDR_W-1:0]   wordAddr;

  // Upper bits stay fixed for the burst; only the low pair moves
  assign selected  = ~sCs1N & sCs2 & ~sCs3N;
  assign procStart = ~sAdspN & ~sCs1N;
  assign wordAddr  = {addr_reg[`SBSC_ADDR_W-1:`SBSC_BURST_W],
                      burstLow(addr_reg[`SBSC_BURST_W-1:0], cnt_reg,
                               burstOrderSel)};
  assign wordAddrNext = {addr_next[`SBSC_ADDR_W-1:`SBSC_BURST_W],
                         burstLow(addr_next[`SBSC_BURST_W-1:0], cnt_next,
                                  burstOrderSel)};

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    cnt_next   = cnt_reg;
    memWe      = '0;
    if (srst) begin
      state_next = sbsc_pkg::ST_IDLE;
      addr_next  = `SBSC_ADDR_RST;
      cnt_next   = `SBSC_CNT_RST;
    end else if (ce) begin
      if (procStart) begin
        // Processor strobe starts a read when selected, else deselects; writes need a later cycle
        if (selected) begin
          state_next = sbsc_pkg::ST_READ;
          addr_next  = sAddr;
          cnt_next   = `SBSC_CNT_RST;
        end else begin
          state_next = sbsc_pkg::ST_IDLE;
        end
      end else if (!sAdscN) begin
        if (selected) begin
          addr_next = sAddr;
          cnt_next  = `SBSC_CNT_RST;
          if (isWrite) begin
            state_next = sbsc_pkg::ST_WRITE;
            memWe      = byteMask;
          end else begin
            state_next = sbsc_pkg::ST_READ;
          end
        end else begin
          state_next = sbsc_pkg::ST_IDLE;
        end
      end else if (state_reg != sbsc_pkg::ST_IDLE) begin
        // Deselected stays deselected: no burst is open to continue
        if (!sStepN) begin
          cnt_next = cnt_reg + `SBSC_CNT_STEP;
        end
        if (isWrite) begin
          state_next = sbsc_pkg::ST_WRITE;
          memWe      = byteMask;
        end else begin
          state_next = sbsc_pkg::ST_READ;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
    addr_reg  <= addr_next;
    cnt_reg   <= cnt_next;
  end

  // Array, one lane per byte so each lane has a single writer
  logic [`SBSC_DATA_W-1:0] rdWord;

  for (genvar b = 0; b < `SBSC_BYTES; b++) begin : gLane
    logic [`SBSC_BYTE_W-1:0] memByte [`SBSC_DEPTH];

    // Self-timed: data and mask taken on the edge, no write pulse
    always_ff @(posedge clk) begin
      if (memWe[b]) begin
        memByte[wordAddrNext] <=
          sData[b*`SBSC_BYTE_W +: `SBSC_BYTE_W];
      end
    end

    assign rdWord[b*`SBSC_BYTE_W +: `SBSC_BYTE_W] =
      memByte[wordAddr];
  end

  // Flow-through and async enable: no flop can sit on these paths.
  // Relies on the controller keeping output enable high around writes.
  assign dataIoOut = rdWord;
  assign dataIoOe  = (state_reg == sbsc_pkg::ST_READ)
                   & ~outEnN;

endmodule : sbsc_sync_burst_sram_control
`default_nettype wire

// *** tb_top.sv ***
// Bench: byte-write table, deselects, bursts in both orders.
// Assumes pins are decoded two enabled edges after sampling.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"
module tb_top;
  logic clk = 0, srst = 1, oeWant = 1, order = 0, outEnN, dataIoOe;
  logic [9:0] ctl = 10'h2FF;
  logic [15:0] addr = 16'h0000;
  logic [17:0] din = 18'h0_0000, dataIoOut;
  int errors = 0, compares = 0, cyc = 0, s, j;
  // Byte-only rows keep global write high
  logic [3:0] rWb[7] = '{4'h7, 4'h9, 4'hA, 4'hB, 4'h8, 4'h0, 4'hC};
  logic [17:0] rDat[7] = '{18'h3_FFFF, 18'h0, 18'h0, 18'h3_FFFF,
    18'h1_2345, 18'h0_0F0F, 18'h3_FFFF};
  logic [17:0] rExp[7] = '{18'h3_FFFF, 18'h3_FE00, 18'h0, 18'h0,
    18'h1_2345, 18'h0_0F0F, 18'h0_0F0F};
  logic [5:0] dsel[4] = '{6'h35, 6'h1B, 6'h05, 6'h03};
  always #5 clk = ~clk;
  sbsc_cache_ctl cache (.clk(clk), .srst(srst), .wrInd(!ctl[3] || !ctl[2]),
    .oeWant(oeWant), .outEnN(outEnN));
  sbsc_sync_burst_sram_control dut (.clk(clk), .srst(srst), .ce(1'b1),
    .chipSelFirstN(ctl[9]), .depthSelHigh(ctl[8]), .depthSelLowN(ctl[7]),
    .procAddrStrobeN(ctl[6]), .ctrlAddrStrobeN(ctl[5]),
    .burstStepN(ctl[4]), .globalWriteN(ctl[3]),
    .byteQualifiedWriteN(ctl[2]), .byteLowWriteN(ctl[1]),
    .byteHighWriteN(ctl[0]), .outEnN(outEnN), .burstOrderSel(order),
    .addressIn(addr), .dataIoIn(din), .dataIoOut(dataIoOut),
    .dataIoOe(dataIoOe));
  task automatic pins(input logic [9:0] c, input logic [15:0] a,
                      input logic [17:0] d);
    ctl <= c;
    addr <= a;
    din <= d;
  endtask : pins
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chkW(input logic [17:0] g, input logic [17:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: data %h, want %h", $time, g, e);
    end
  endtask : chkW
  task automatic chkB(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: drive %b, want %b", $time, g, e);
    end
  endtask : chkB
  task automatic test_done;
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    tick(5);
    srst <= 0;
    tick(3);
    #1 chkB(dataIoOe, 1'b0);
    for (int i = 0; i < 7; i++) begin
      tick(1);
      pins({6'h15, rWb[i]}, 16'h0010, rDat[i]);
      tick(1);
      pins({6'h17, 4'hF}, 16'h0010, 18'h0);
      tick(4);
      #1 chkW(dataIoOut, rExp[i]);
      chkB(dataIoOe, 1'b1);
    end
    // Each deselect interrupts a live read, then a continue must not wake it
    foreach (dsel[i]) begin
      tick(1);
      pins({6'h13, 4'hF}, 16'h0010, 18'h0);
      tick(1);
      pins({dsel[i], 4'hF}, 16'h0010, 18'h0);
      tick(1);
      pins({6'h16, 4'hF}, 16'h0010, 18'h0);
      tick(4);
      #1 chkB(dataIoOe, 1'b0);
    end
    tick(1);
    pins({6'h15, 4'h7}, 16'h0100, 18'h0_0100);
    for (int k = 1; k < 4; k++) begin
      tick(1);
      pins({6'h16, 4'h7}, 16'h0100, 18'h0_0100 + 18'(k));
    end
    tick(1);
    pins({6'h17, 4'hF}, 16'h0100, 18'h0);
    tick(4);
    for (int m = 0; m < 4; m++) begin
      s = m[0] + 1;
      tick(1);
      oeWant <= 0;
      order <= m[1];
      tick(1);
      oeWant <= 1;
      pins({6'h13, 4'hF}, 16'h0100 + 16'(s), 18'h0);
      tick(1);
      pins({6'h16, 4'hF}, 16'h0100, 18'h0);
      tick(1);
      for (int k = 0; k < 5; k++) begin
        tick(1);
        if (k == 1) pins({6'h17, 4'hF}, 16'h0100, 18'h0);
        j = (k > 3) ? 3 : k;
        #1 chkW(dataIoOut,
                18'h0_0100 + 18'(m[1] ? s ^ j : (s + j) % 4));
      end
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
